// ==== verilog/qrb_params.svh ====
// Constants for the burst SRAM port logic.
// Function
// - Inputs and outputs registered on link edges only; the code registers every pin and the echo outputs on each clk edge
// - Four arrays, four-word burst over two cycles
// - Read select low at true rise captures address
// - First read word two true rises later
// - Read request on next true rise ignored
// - After pending reads, outputs float next rise
// - Write select low at true rise captures address
// - Latch four words, then commit whole burst
// - Write request on next true rise ignored
// - Deselected write port ignores inputs after bursts
// - Lane enables sampled per word, gate storing
// - Read and write ports operate independently
// - Read after write returns newest data
// - Both selected: history decides, read first
// - Port selects sampled on true rises only
// - Deselecting one port leaves other unaffected
// - Impedance update every fixed count of cycles
// - Two free-running echo clocks follow input clocks
// - Valid flag half cycle ahead of data
// - Loop locks after fixed count of clocks
// - Burst words map to four arrays at one address
`ifndef QRB_PARAMS_SVH
`define QRB_PARAMS_SVH
`define QRB_ADDR_W 20
`define QRB_WORD_W 18
`define QRB_LANE_W 9
`define QRB_LANES 2
`define QRB_BURST 4
`define QRB_ZQ_CYCLES 1024
`define QRB_ZQ_CNT_W 10
`define QRB_DLL_CYCLES 2048
`define QRB_DLL_CNT_W 11
`define QRB_BUF_DEPTH 2
`endif

// ==== verilog/qrb_pkg.sv ====
// Types shared by the burst SRAM port logic.
`include "qrb_params.svh"
package qrb_pkg;
   typedef logic [`QRB_ADDR_W-1:0] qrb_addr_t;
   typedef logic [`QRB_WORD_W-1:0] qrb_word_t;
   typedef logic [`QRB_LANES-1:0] qrb_lane_t;
   typedef qrb_word_t [`QRB_BURST-1:0] qrb_burst_t;

   typedef struct packed {
      logic true_phase;
      logic inverse_phase;
      logic read_port_select_n;
      logic write_port_select_n;
      qrb_addr_t address;
      qrb_word_t write_data;
      qrb_lane_t lane_write_enable_n;
      logic delay_loop_disable_n;
   } qrb_pins_t;

   typedef struct packed {
      qrb_burst_t word;
      qrb_lane_t [`QRB_BURST-1:0] lane_write_enable_n;
      qrb_addr_t addr;
   } qrb_wbuf_t;

   typedef enum logic [2:0] {
      QRB_WR_IDLE = 3'b000,
      QRB_WR_W0 = 3'b001,
      QRB_WR_W1 = 3'b010,
      QRB_WR_W2 = 3'b011,
      QRB_WR_W3 = 3'b100
   } qrb_wph_t;
endpackage

// ==== verilog/qrb_mem.sv ====
// One internal array: a lane-gated write port and a registered read port.
`include "qrb_params.svh"
module qrb_mem
   import qrb_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic we,
   input wire qrb_lane_t lane_en,
   input wire qrb_addr_t waddr,
   input wire qrb_word_t wdata,
   input wire logic re,
   input wire qrb_addr_t raddr,
   output qrb_word_t rdata
);
   qrb_word_t mem_r [2**`QRB_ADDR_W];
   qrb_word_t rdata_r;
   qrb_word_t rdata_nxt;

   always_comb
   begin
      rdata_nxt = re ? mem_r[raddr] : rdata_r;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         rdata_r <= 18'h00000;
      else
         rdata_r <= rdata_nxt;
   end

   // The array itself is not reset; its content is undefined until written.
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < `QRB_LANES; i++)
      begin
         if (we && lane_en[i])
            mem_r[waddr][i*`QRB_LANE_W +: `QRB_LANE_W] <= wdata[i*`QRB_LANE_W +: `QRB_LANE_W];
      end
   end

   assign rdata = rdata_r;
endmodule

// ==== verilog/qrb_buf.sv ====
// Small FIFO with valid and ready on both sides.
module qrb_buf #(
   parameter int W = 8,
   parameter int DEPTH = 2
)(
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
   logic [W-1:0] slot_r [DEPTH];
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [PW:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign in_ready = (cnt_r != FULL);
   assign out_valid = (cnt_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_ready && out_valid;
   assign out_data = slot_r[rp_r];

   // Depth must be a power of two so that the pointers wrap by overflow.
   always_comb
   begin
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r;
      if (push && !pop)
         cnt_nxt = cnt_r + 1'b1;
      else if (pop && !push)
         cnt_nxt = cnt_r - 1'b1;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
         slot_r[wp_r] <= in_data;
   end
endmodule

// ==== verilog/qrb_ports.sv ====
// Port logic of the separate-port four-word burst SRAM.
`include "qrb_params.svh"
module qrb_ports
   import qrb_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic true_phase_input,
   input wire logic inverse_phase_input,
   input wire logic read_port_select_n,
   input wire logic write_port_select_n,
   input wire qrb_addr_t address,
   input wire qrb_word_t write_data,
   input wire qrb_lane_t lane_write_enable_n,
   input wire logic delay_loop_disable_n,
   output qrb_word_t read_data,
   output logic read_data_oe_n,
   output logic [1:0] echo_timing_output,
   output logic output_valid_flag,
   output logic impedance_update,
   output logic delay_loop_locked
);
   localparam logic [`QRB_ZQ_CNT_W-1:0] ZQ_LAST = `QRB_ZQ_CNT_W'(`QRB_ZQ_CYCLES - 1);
   localparam logic [`QRB_DLL_CNT_W-1:0] DLL_LAST = `QRB_DLL_CNT_W'(`QRB_DLL_CYCLES - 1);

   qrb_pins_t pin_in, sy1_r, sy2_r;
   logic k_d_r, kn_d_r, kr, knr;

   // All pins share one synchroniser so that data stay aligned to the clock edges.
   assign pin_in = {true_phase_input, inverse_phase_input, read_port_select_n, write_port_select_n,
                    address, write_data, lane_write_enable_n, delay_loop_disable_n};

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sy1_r <= '0;
         sy2_r <= '0;
         k_d_r <= 1'b0;
         // The inverse pin idles high, so a low value here would fake a rise after reset.
         kn_d_r <= 1'b1;
      end
      else
      begin
         sy1_r <= pin_in;
         sy2_r <= sy1_r;
         k_d_r <= sy2_r.true_phase;
         kn_d_r <= sy2_r.inverse_phase;
      end
   end

   assign kr = sy2_r.true_phase && !k_d_r;
   assign knr = sy2_r.inverse_phase && !kn_d_r;

   logic rd_p1_r, rd_p1_nxt, rd_p2_r, rd_p2_nxt, wr_p1_r, wr_p1_nxt;
   logic rd_go, wr_go, rd_req, wr_req, buf_in_ready, buf_out_valid, load;
   qrb_addr_t ra_r, ra_nxt, wa_r, wa_nxt;

   // Selects are looked at only on true rises; a busy port refuses the second request.
   assign rd_req = kr && !sy2_r.read_port_select_n && !rd_p1_r && buf_in_ready;
   assign wr_req = kr && !sy2_r.write_port_select_n && !wr_p1_r;
   // A busy read port lets the write through, so the history rule reduces to read-first.
   assign rd_go = rd_req;
   assign wr_go = wr_req && !rd_req;

   always_comb
   begin
      rd_p1_nxt = rd_p1_r;
      rd_p2_nxt = rd_p2_r;
      wr_p1_nxt = wr_p1_r;
      ra_nxt = ra_r;
      wa_nxt = wa_r;
      if (kr)
      begin
         rd_p1_nxt = rd_go;
         rd_p2_nxt = rd_p1_r;
         wr_p1_nxt = wr_go;
         if (rd_go)
            ra_nxt = sy2_r.address;
         if (wr_go)
            wa_nxt = sy2_r.address;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rd_p1_r <= 1'b0;
         rd_p2_r <= 1'b0;
         wr_p1_r <= 1'b0;
         ra_r <= '0;
         wa_r <= '0;
      end
      else
      begin
         rd_p1_r <= rd_p1_nxt;
         rd_p2_r <= rd_p2_nxt;
         wr_p1_r <= wr_p1_nxt;
         ra_r <= ra_nxt;
         wa_r <= wa_nxt;
      end
   end

   qrb_wph_t wph_r, wph_nxt;
   qrb_wbuf_t wb_r, wb_nxt;
   logic wpend_r, wpend_nxt, fwd_r, fwd_nxt, mem_we, mem_re, mrv_r;

   always_comb
   begin
      wph_nxt = wph_r;
      wb_nxt = wb_r;
      wpend_nxt = wpend_r;
      mem_we = 1'b0;
      unique case (wph_r)
         QRB_WR_IDLE:
            if (wr_go)
               wph_nxt = QRB_WR_W0;
         QRB_WR_W0:
            if (kr)
            begin
               wb_nxt.addr = wa_r;
               wb_nxt.word[0] = sy2_r.write_data;
               wb_nxt.lane_write_enable_n[0] = sy2_r.lane_write_enable_n;
               wph_nxt = QRB_WR_W1;
            end
         QRB_WR_W1:
            if (knr)
            begin
               wb_nxt.word[1] = sy2_r.write_data;
               wb_nxt.lane_write_enable_n[1] = sy2_r.lane_write_enable_n;
               wph_nxt = QRB_WR_W2;
            end
         QRB_WR_W2:
            if (kr)
            begin
               wb_nxt.word[2] = sy2_r.write_data;
               wb_nxt.lane_write_enable_n[2] = sy2_r.lane_write_enable_n;
               wpend_nxt = wr_go;
               wph_nxt = QRB_WR_W3;
            end
         QRB_WR_W3:
            if (knr)
            begin
               wb_nxt.word[3] = sy2_r.write_data;
               wb_nxt.lane_write_enable_n[3] = sy2_r.lane_write_enable_n;
               mem_we = 1'b1;
               wpend_nxt = 1'b0;
               // A burst in flight is always finished, even if the port was deselected.
               wph_nxt = wpend_r ? QRB_WR_W0 : QRB_WR_IDLE;
            end
         default:
            wph_nxt = QRB_WR_IDLE;
      endcase
   end

   // A commit after the read's array access but before its output is forwarded.
   always_comb
   begin
      fwd_nxt = fwd_r;
      if (load)
         fwd_nxt = 1'b0;
      if (mem_we && rd_p2_r && wb_r.addr == ra_r)
         fwd_nxt = 1'b1;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wph_r <= QRB_WR_IDLE;
         wb_r <= '0;
         wpend_r <= 1'b0;
         fwd_r <= 1'b0;
         mrv_r <= 1'b0;
      end
      else
      begin
         wph_r <= wph_nxt;
         wb_r <= wb_nxt;
         wpend_r <= wpend_nxt;
         fwd_r <= fwd_nxt;
         mrv_r <= mem_re;
      end
   end

   assign mem_re = kr && rd_p1_r;
   wire qrb_burst_t rd_burst;

   // Word i of every burst lives in array i at the burst address.
   for (genvar gi = 0; gi < `QRB_BURST; gi++)
   begin : g_arr
      qrb_mem u_mem (
         .clk(clk),
         .reset(reset),
         .we(mem_we),
         .lane_en(~((gi == `QRB_BURST - 1) ? sy2_r.lane_write_enable_n : wb_r.lane_write_enable_n[gi])),
         .waddr(wb_r.addr),
         .wdata((gi == `QRB_BURST - 1) ? sy2_r.write_data : wb_r.word[gi]),
         .re(mem_re),
         .raddr(ra_r),
         .rdata(rd_burst[gi])
      );
   end

   qrb_burst_t buf_q, merged;

   // Holding the burst here lets a late output slot never drop an array read.
   qrb_buf #(
      .W($bits(qrb_burst_t)),
      .DEPTH(`QRB_BUF_DEPTH)
   ) u_buf (
      .clk(clk),
      .reset(reset),
      .in_valid(mrv_r),
      .in_ready(buf_in_ready),
      .in_data(rd_burst),
      .out_valid(buf_out_valid),
      .out_ready(load),
      .out_data(buf_q)
   );

   always_comb
   begin
      merged = buf_q;
      for (int i = 0; i < `QRB_BURST; i++)
      begin
         for (int j = 0; j < `QRB_LANES; j++)
         begin
            if (fwd_r && !wb_r.lane_write_enable_n[i][j])
               merged[i][j*`QRB_LANE_W +: `QRB_LANE_W] = wb_r.word[i][j*`QRB_LANE_W +: `QRB_LANE_W];
         end
      end
   end

   assign load = kr && rd_p2_r && buf_out_valid;

   qrb_burst_t ob_r, ob_nxt;
   qrb_word_t q_r, q_nxt;
   logic [1:0] oidx_r, oidx_nxt;
   logic oact_r, oact_nxt, oe_n_r, oe_n_nxt, vld_r, vld_nxt;

   always_comb
   begin
      ob_nxt = ob_r;
      q_nxt = q_r;
      oidx_nxt = oidx_r;
      oact_nxt = oact_r;
      oe_n_nxt = oe_n_r;
      vld_nxt = vld_r;
      if (load)
      begin
         ob_nxt = merged;
         q_nxt = merged[0];
         oidx_nxt = 2'h0;
         oact_nxt = 1'b1;
         oe_n_nxt = 1'b0;
      end
      else if (kr && oact_r && oidx_r == 2'h1)
      begin
         q_nxt = ob_r[2];
         oidx_nxt = 2'h2;
      end
      else if (kr && oact_r && oidx_r == 2'h3)
      begin
         oact_nxt = 1'b0;
         oe_n_nxt = 1'b1;
      end
      if (knr)
      begin
         if (oact_r && !oidx_r[0])
         begin
            q_nxt = ob_r[oidx_r + 2'h1];
            oidx_nxt = oidx_r + 2'h1;
         end
         // Flag rises on the inverse rise that precedes a valid word.
         vld_nxt = rd_p2_r || (oact_r && oidx_r == 2'h0);
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ob_r <= '0;
         q_r <= '0;
         oidx_r <= 2'h0;
         oact_r <= 1'b0;
         oe_n_r <= 1'b1;
         vld_r <= 1'b0;
      end
      else
      begin
         ob_r <= ob_nxt;
         q_r <= q_nxt;
         oidx_r <= oidx_nxt;
         oact_r <= oact_nxt;
         oe_n_r <= oe_n_nxt;
         vld_r <= vld_nxt;
      end
   end

   logic [1:0] echo_r;
   logic [`QRB_ZQ_CNT_W-1:0] zq_cnt_r, zq_cnt_nxt;
   logic [`QRB_DLL_CNT_W-1:0] dll_cnt_r, dll_cnt_nxt;
   logic imp_r, imp_nxt, lock_r, lock_nxt;

   always_comb
   begin
      zq_cnt_nxt = kr ? zq_cnt_r + 1'b1 : zq_cnt_r;
      imp_nxt = kr && zq_cnt_r == ZQ_LAST;
      dll_cnt_nxt = dll_cnt_r;
      lock_nxt = lock_r;
      if (!sy2_r.delay_loop_disable_n)
      begin
         dll_cnt_nxt = '0;
         lock_nxt = 1'b0;
      end
      else if (kr && !lock_r)
      begin
         dll_cnt_nxt = dll_cnt_r + 1'b1;
         lock_nxt = dll_cnt_r == DLL_LAST;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         echo_r <= 2'h0;
         zq_cnt_r <= '0;
         imp_r <= 1'b0;
         dll_cnt_r <= '0;
         lock_r <= 1'b0;
      end
      else
      begin
         echo_r <= {sy2_r.inverse_phase, sy2_r.true_phase};
         zq_cnt_r <= zq_cnt_nxt;
         imp_r <= imp_nxt;
         dll_cnt_r <= dll_cnt_nxt;
         lock_r <= lock_nxt;
      end
   end

   assign read_data = q_r;
   assign read_data_oe_n = oe_n_r;
   assign echo_timing_output = echo_r;
   assign output_valid_flag = vld_r;
   assign impedance_update = imp_r;
   assign delay_loop_locked = lock_r;

   property p_rd_gap;
      @(posedge clk) disable iff (reset) (kr && rd_p1_r) |-> !rd_go && rd_p2_nxt;
   endproperty
   a_rd_gap: assert property (p_rd_gap)
      else $error("read accepted on consecutive true rises");

   property p_wr_gap;
      @(posedge clk) disable iff (reset) (kr && wr_p1_r) |-> !wr_go;
   endproperty
   a_wr_gap: assert property (p_wr_gap)
      else $error("write accepted on consecutive true rises");

   property p_one_start;
      @(posedge clk) disable iff (reset) !(rd_go && wr_go) && !((rd_go || wr_go) && !kr);
   endproperty
   a_one_start: assert property (p_one_start)
      else $error("two starts or a start off a true rise");

   property p_arb;
      @(posedge clk) disable iff (reset)
         (kr && !sy2_r.read_port_select_n && !sy2_r.write_port_select_n && !rd_p1_r && buf_in_ready) |-> rd_go;
   endproperty
   a_arb: assert property (p_arb)
      else $error("read lost arbitration after idle or write");

   property p_first_word;
      @(posedge clk) disable iff (reset) load |=> !read_data_oe_n && read_data == $past(merged[0]);
   endproperty
   a_first_word: assert property (p_first_word)
      else $error("first read word not driven at load");

   property p_float;
      @(posedge clk) disable iff (reset) (kr && oact_r && oidx_r == 2'h3 && !load) |=> read_data_oe_n ##1 !oact_r;
   endproperty
   a_float: assert property (p_float)
      else $error("read outputs not floated after burst");

   property p_vld;
      @(posedge clk) disable iff (reset) (knr && rd_p2_r) |=> output_valid_flag [*2];
   endproperty
   a_vld: assert property (p_vld)
      else $error("valid flag not raised ahead of data");

   property p_commit;
      @(posedge clk) disable iff (reset) mem_we |-> knr && $past(wph_r, 1) == QRB_WR_W3;
   endproperty
   a_commit: assert property (p_commit)
      else $error("write committed outside the last word slot");

   property p_zq;
      @(posedge clk) disable iff (reset) impedance_update |-> zq_cnt_r == '0 ##1 !impedance_update;
   endproperty
   a_zq: assert property (p_zq)
      else $error("impedance update off its period");

   property p_echo;
      @(posedge clk) disable iff (reset)
         ##1 echo_timing_output == {$past(sy2_r.inverse_phase), $past(sy2_r.true_phase)};
   endproperty
   a_echo: assert property (p_echo)
      else $error("echo clocks do not follow input clocks");
endmodule

// ==== verif/qrb_host.sv ====
// Host controller model: link clocks, request pins and read-side sampling.
module qrb_host
   import qrb_pkg::*;
(
   output logic true_phase_input,
   output logic inverse_phase_input,
   output logic read_port_select_n,
   output logic write_port_select_n,
   output qrb_addr_t address,
   output qrb_word_t write_data,
   output qrb_lane_t lane_write_enable_n,
   input wire qrb_word_t read_data,
   input wire logic read_data_oe_n,
   input wire logic output_valid_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   int ni = 0;
   qrb_word_t q_t [0:255];
   qrb_word_t q_i [0:255];
   logic oe_t [0:255];
   logic fl_i [0:255];
   qrb_word_t bus_q;

   // A floating read bus shows the inverse of the register, so stale data never passes.
   assign bus_q = (read_data_oe_n === 1'b0) ? read_data : ~read_data;

   initial
   begin
      true_phase_input = 1'b0;
      inverse_phase_input = 1'b1;
      read_port_select_n = 1'b1;
      write_port_select_n = 1'b1;
      address = '0;
      write_data = '0;
      lane_write_enable_n = '1;
      #800;
      forever
      begin
         true_phase_input = ~true_phase_input;
         inverse_phase_input = ~true_phase_input;
         #400;
      end
   end

   // Words are sampled 500 ns after each rise, 100 ns into the next phase, after the device's synchroniser delay has passed.
   always
   begin
      @(posedge true_phase_input);
      n = n + 1;
      #500;
      if (n < 256)
      begin
         q_t[n] = bus_q;
         oe_t[n] = read_data_oe_n;
      end
   end

   always
   begin
      @(posedge inverse_phase_input);
      ni = n;
      #500;
      if (ni < 256)
      begin
         q_i[ni] = bus_q;
         fl_i[ni] = output_valid_flag;
      end
   end

   // Drives one true rise worth of requests and the two data words of that cycle.
   task automatic link_cycle(input logic r_n, input logic w_n, input qrb_addr_t a, input qrb_word_t d0,
      input qrb_lane_t l0, input qrb_word_t d1, input qrb_lane_t l1, output int c);
      @(posedge inverse_phase_input);
      #200;
      c = n + 1;
      read_port_select_n = r_n;
      write_port_select_n = w_n;
      address = a;
      write_data = d0;
      lane_write_enable_n = l0;
      @(posedge true_phase_input);
      #200;
      write_data = d1;
      lane_write_enable_n = l1;
   endtask
endmodule

// ==== verif/test_quad_rate_burst_sram_ports.sv ====
// Self-checking bench for the burst SRAM port logic.
`include "qrb_params.svh"
module test_quad_rate_burst_sram_ports
   import qrb_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic delay_loop_disable_n = 1'b1;
   logic true_phase_input, inverse_phase_input, read_port_select_n, write_port_select_n;
   logic read_data_oe_n, output_valid_flag, impedance_update, delay_loop_locked;
   logic [1:0] echo_timing_output;
   qrb_addr_t address;
   qrb_word_t write_data, read_data;
   qrb_lane_t lane_write_enable_n;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   int pulses = 0;
   int p_prev = 0;
   int p_cur = -5000;
   qrb_burst_t exp_m [qrb_addr_t];

   always #50 clk = ~clk;

   qrb_host host_u (.true_phase_input, .inverse_phase_input, .read_port_select_n, .write_port_select_n,
      .address, .write_data, .lane_write_enable_n, .read_data, .read_data_oe_n, .output_valid_flag);

   qrb_ports dut_u (.clk, .reset, .true_phase_input, .inverse_phase_input, .read_port_select_n,
      .write_port_select_n, .address, .write_data, .lane_write_enable_n, .delay_loop_disable_n,
      .read_data, .read_data_oe_n, .echo_timing_output, .output_valid_flag, .impedance_update,
      .delay_loop_locked);

   always @(negedge clk)
   begin
      cycles++;
      if (impedance_update === 1'b1)
      begin
         pulses++;
         p_prev = p_cur;
         p_cur = host_u.n;
      end
      if (cycles == 30000)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: run hung", $time);
         finish_test();
      end
   end

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Idle cycles keep every lane enabled, so any stray word taken by the device shows up.
   task automatic idle(input int k);
      int c;
      repeat (k)
         host_u.link_cycle(1'b1, 1'b1, 20'h5a5a5, 18'h2aaaa, 2'h0, 18'h15555, 2'h0, c);
   endtask

   task automatic model_wr(input qrb_addr_t a, input qrb_burst_t d, input logic [7:0] l);
      for (int i = 0; i < 4; i++)
         for (int b = 0; b < 2; b++)
            if (!l[2*i+b])
               exp_m[a][i][b*`QRB_LANE_W +: `QRB_LANE_W] = d[i][b*`QRB_LANE_W +: `QRB_LANE_W];
   endtask

   task automatic wr(input qrb_addr_t a, input qrb_burst_t d, input logic [7:0] l);
      int c;
      host_u.link_cycle(1'b1, 1'b0, a, ~d[0], 2'h0, ~d[1], 2'h0, c);
      host_u.link_cycle(1'b1, 1'b1, ~a, d[0], l[1:0], d[1], l[3:2], c);
      host_u.link_cycle(1'b1, 1'b1, ~a, d[2], l[5:4], d[3], l[7:6], c);
      model_wr(a, d, l);
   endtask

   task automatic rd_chk(input int t, input qrb_addr_t a);
      chk(host_u.fl_i[t+1], 1'b1, "flag ahead of data");
      chk(host_u.oe_t[t+2], 1'b0, "read bus driven");
      for (int i = 0; i < 4; i++)
         chk(i[0] ? host_u.q_i[t+2+i/2] : host_u.q_t[t+2+i/2], exp_m[a][i], "burst word");
   endtask

   // Two reads on every other true rise, then the drain and both comparisons.
   task automatic rd2(input qrb_addr_t a1, input qrb_addr_t a2, output int t1, output int t2);
      int c;
      host_u.link_cycle(1'b0, 1'b1, a1, 18'h0, 2'h0, 18'h0, 2'h0, t1);
      host_u.link_cycle(1'b1, 1'b1, ~a1, 18'h0, 2'h0, 18'h0, 2'h0, c);
      host_u.link_cycle(1'b0, 1'b1, a2, 18'h0, 2'h0, 18'h0, 2'h0, t2);
      idle(5);
      rd_chk(t1, a1);
      rd_chk(t2, a2);
   endtask

   task automatic s_burst();
      int t1, t2;
      wr(20'h00010, {18'h3a001, 18'h2b002, 18'h1c003, 18'h0d004}, 8'h00);
      wr(20'h00011, {18'h11111, 18'h22222, 18'h33333, 18'h04444}, 8'h00);
      rd2(20'h00010, 20'h00011, t1, t2);
      chk(host_u.fl_i[t1+3], 1'b1, "flag held between bursts");
      chk(host_u.oe_t[t1+4], 1'b0, "continuous read data");
      chk(host_u.oe_t[t2+4], 1'b1, "read bus released");
      chk(host_u.fl_i[t2+3], 1'b0, "flag low after last word");
   endtask

   task automatic s_lanes();
      int t1, t2;
      wr(20'h00020, {4{18'h3ffff}}, 8'h00);
      wr(20'h00020, {4{18'h00000}}, 8'he4);
      rd2(20'h00020, 20'h00010, t1, t2);
   endtask

   task automatic s_refuse();
      int t, c, t1, t2;
      host_u.link_cycle(1'b0, 1'b1, 20'h00010, 18'h0, 2'h0, 18'h0, 2'h0, t);
      host_u.link_cycle(1'b0, 1'b1, 20'h00011, 18'h0, 2'h0, 18'h0, 2'h0, c);
      idle(4);
      rd_chk(t, 20'h00010);
      chk(host_u.oe_t[t+4], 1'b1, "second read ignored");
      host_u.link_cycle(1'b1, 1'b0, 20'h00030, 18'h0, 2'h3, 18'h0, 2'h3, c);
      host_u.link_cycle(1'b1, 1'b0, 20'h00011, 18'h12345, 2'h0, 18'h12345, 2'h0, c);
      host_u.link_cycle(1'b1, 1'b1, 20'h00011, 18'h12345, 2'h0, 18'h12345, 2'h0, c);
      model_wr(20'h00030, {4{18'h12345}}, 8'h00);
      idle(2);
      rd2(20'h00011, 20'h00030, t1, t2);
   endtask

   // Both selects held low from idle: read, write, read, with the last read hitting the write.
   task automatic s_arbitrate();
      int t0, t1, t2;
      host_u.link_cycle(1'b0, 1'b0, 20'h00010, 18'h0, 2'h0, 18'h0, 2'h0, t0);
      host_u.link_cycle(1'b0, 1'b0, 20'h00010, 18'h0, 2'h0, 18'h0, 2'h0, t1);
      host_u.link_cycle(1'b0, 1'b0, 20'h00010, 18'h2f00f, 2'h0, 18'h2f00f, 2'h1, t2);
      host_u.link_cycle(1'b1, 1'b1, 20'h00010, 18'h2f00f, 2'h2, 18'h2f00f, 2'h0, t1);
      idle(4);
      rd_chk(t0, 20'h00010);
      model_wr(20'h00010, {4{18'h2f00f}}, 8'h24);
      rd_chk(t2, 20'h00010);
   endtask

   task automatic s_echo();
      repeat (2)
      begin
         @(posedge true_phase_input);
         #500;
         chk(echo_timing_output, 2'h1, "echo after true rise");
         @(posedge inverse_phase_input);
         #500;
         chk(echo_timing_output, 2'h2, "echo after inverse rise");
      end
   endtask

   task automatic s_counts();
      wait (host_u.n == 2047);
      #500;
      chk(delay_loop_locked, 1'b0, "lock too early");
      wait (host_u.n == 2048);
      #500;
      chk(delay_loop_locked, 1'b1, "lock after count");
      chk(p_cur - p_prev, 1024, "impedance update spacing");
      chk(pulses, 2, "impedance update pulses");
      delay_loop_disable_n = 1'b0;
      repeat (2) @(posedge true_phase_input);
      #500;
      chk(delay_loop_locked, 1'b0, "lock cleared");
   endtask

   initial
   begin
      #200;
      reset = 1'b0;
      s_burst();
      s_lanes();
      s_refuse();
      s_arbitrate();
      s_echo();
      s_counts();
      finish_test();
   end
endmodule
